// ### src/sync_serial_port.sv
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.svh"

// Overview of operation
// - Clock source bit 7 low gives unit clock of system clock over four.
// - Mode bits: 00,01,10 master at unit (unit/2 with bit 7 high), /4, /16; 11 slave.
// - Bus enable bit 4 low leaves all serial pins undriven.
// - On enabling, data line and, in master, clock line driven low, then await data write.
// - Master: data write loads shift buffer and starts full-duplex transfer.
// - Master: done flag set once all bits are shifted.
// - Slave: each received clock, while selected, shifts out and in.
// - Bit order bit 3: one shifts MSB first, zero LSB first.
// - Select enable bit 2 turns select on; off leaves select pin floating.
// - Data write during a transfer sets collision bit 1, value discarded.
// - Done flag bit 0 set on completion and drives the interrupt.
// - Reception continues while the processor is halted.
// - Data writes reach only shift buffer; reads return the data register.
// - At transfer end received bits are copied into the data register.
// - Build option picks rising (1) or falling (0) sampling edge.
// - Clearing bus enable returns all status flags to cleared.
module sync_serial_port #(
	parameter bit CLOCK_POLARITY_OPT = 1'b1
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        serial_clk_i,
	output logic             serial_clk_o,
	output logic             serial_clk_oe_o,
	input  wire logic        serial_in_i,
	output logic             serial_out_o,
	output logic             serial_out_oe_o,
	input  wire logic        slave_select_n_i,
	output logic             slave_select_n_o,
	output logic             slave_select_n_oe_o,
	output logic             serial_bus_irq_o
);

	localparam logic [7:0] CTRL_RST = `SSP_CTRL_RST;

	logic                clk_src_ff;
	logic [1:0]          mode_ff;
	logic                bus_en_ff;
	logic                bus_en_d_ff;
	logic                order_ff;
	logic                sel_en_ff;
	logic                write_collision_flag_ff;
	logic                trf_ff;
	logic [7:0]          data_reg_ff;
	logic [7:0]          shift_buf_ff;
	ssp_pkg::xfer_state_t state_ff;
	logic [4:0]          edge_cnt_ff;
	logic [4:0]          div_cnt_ff;
	logic                sclk_ff;
	logic                sdo_ff;
	logic                ss_n_ff;
	logic                sclk_oe_ff;
	logic                sdo_oe_ff;
	logic                ss_oe_ff;
	logic                pready_ff;
	logic                pslverr_ff;
	logic [31:0]         prdata_ff;
	logic                sck_s1_ff;
	logic                sck_s2_ff;
	logic                sck_s3_ff;
	logic                sdi_s1_ff;
	logic                sdi_s2_ff;
	logic                ss_s1_ff;
	logic                ss_s2_ff;

	logic       setup;
	logic       access;
	logic       hit_ctrl;
	logic       hit_data;
	logic       wr_ctrl;
	logic       wr_data;
	logic       master;
	logic       busy;
	logic       selected;
	logic       m_tick;
	logic       s_tick;
	logic       tick;
	logic       rising;
	logic       sample;
	logic       last;
	logic       start;
	logic       abort;
	logic [4:0] reload;
	logic [4:0] edge_nxt;
	logic [7:0] shifted;
	logic [7:0] ctrl_rd;

	function automatic logic head_bit(input logic msb_first, input logic [7:0] v);
		head_bit = msb_first ? v[7] : v[0];
	endfunction

	// APB decode; one wait-free access phase after each setup
	assign setup    = psel_i & ~penable_i;
	assign access   = psel_i & penable_i & pready_ff;
	assign hit_ctrl = (paddr_i == `SSP_CTRL_OFS);
	assign hit_data = (paddr_i == `SSP_DATA_OFS);
	assign wr_ctrl  = access & pwrite_i & hit_ctrl & pstrb_i[0];
	assign wr_data  = access & pwrite_i & hit_data & pstrb_i[0];

	assign ctrl_rd = {clk_src_ff, mode_ff, bus_en_ff, order_ff,
		sel_en_ff, write_collision_flag_ff, trf_ff};

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready_ff  <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff  <= 32'h0000_0000;
		end else begin
			pready_ff  <= setup;
			pslverr_ff <= setup & ~(hit_ctrl | hit_data);
			if (setup & ~pwrite_i & hit_ctrl) begin
				prdata_ff <= {24'h00_0000, ctrl_rd};
			end else if (setup & ~pwrite_i & hit_data) begin
				prdata_ff <= {24'h00_0000, data_reg_ff};
			end else begin
				prdata_ff <= 32'h0000_0000;
			end
		end
	end

	// Pin synchronisers; the first stage feeds only the second
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sck_s1_ff <= 1'b0;
			sck_s2_ff <= 1'b0;
			sck_s3_ff <= 1'b0;
			sdi_s1_ff <= 1'b0;
			sdi_s2_ff <= 1'b0;
			ss_s1_ff  <= 1'b1;
			ss_s2_ff  <= 1'b1;
		end else begin
			sck_s1_ff <= serial_clk_i;
			sck_s2_ff <= sck_s1_ff;
			sck_s3_ff <= sck_s2_ff;
			sdi_s1_ff <= serial_in_i;
			sdi_s2_ff <= sdi_s1_ff;
			ss_s1_ff  <= slave_select_n_i;
			ss_s2_ff  <= ss_s1_ff;
		end
	end

	// Control fields written by software
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			clk_src_ff <= CTRL_RST[`SSP_CKS_BIT];
			mode_ff    <= CTRL_RST[`SSP_MODE_HI_BIT:`SSP_MODE_LO_BIT];
			bus_en_ff  <= CTRL_RST[`SSP_EN_BIT];
			order_ff   <= CTRL_RST[`SSP_ORDER_BIT];
			sel_en_ff  <= CTRL_RST[`SSP_SEL_EN_BIT];
		end else if (wr_ctrl) begin
			clk_src_ff <= pwdata_i[`SSP_CKS_BIT];
			mode_ff    <= pwdata_i[`SSP_MODE_HI_BIT:`SSP_MODE_LO_BIT];
			bus_en_ff  <= pwdata_i[`SSP_EN_BIT];
			order_ff   <= pwdata_i[`SSP_ORDER_BIT];
			sel_en_ff  <= pwdata_i[`SSP_SEL_EN_BIT];
		end
	end

	assign master   = (mode_ff != `SSP_MODE_SLAVE);
	assign busy     = (state_ff == ssp_pkg::XFER_SHIFT);
	assign selected = ~sel_en_ff | ~ss_s2_ff;

	always_comb begin
		case ({clk_src_ff, mode_ff})
			3'h0:    reload = `SSP_HALF_Q_DIV1;
			3'h1:    reload = `SSP_HALF_Q_DIV4;
			3'h2:    reload = `SSP_HALF_Q_DIV16;
			3'h4:    reload = `SSP_HALF_F_DIV1;
			3'h5:    reload = `SSP_HALF_F_DIV4;
			3'h6:    reload = `SSP_HALF_F_DIV16;
			default: reload = `SSP_HALF_Q_DIV1;
		endcase
	end

	assign m_tick = bus_en_ff & busy & master & (div_cnt_ff == 5'h00);
	assign s_tick = bus_en_ff & ~master & selected & (sck_s2_ff ^ sck_s3_ff);
	assign tick   = m_tick | s_tick;
	assign rising = master ? ~sclk_ff : sck_s2_ff;
	assign sample = (rising == CLOCK_POLARITY_OPT);
	assign edge_nxt = edge_cnt_ff + 5'h01;
	assign last  = tick & (edge_nxt == `SSP_EDGES);
	assign start = bus_en_ff & wr_data & ~busy & master;
	assign abort = busy & ~master & ~selected;

	assign shifted = order_ff ? {shift_buf_ff[6:0], sdi_s2_ff}
		: {sdi_s2_ff, shift_buf_ff[7:1]};

	// Transfer sequencing; runs on during halt, no halt gating
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff    <= ssp_pkg::XFER_IDLE;
			edge_cnt_ff <= 5'h00;
		end else if (~bus_en_ff) begin
			state_ff    <= ssp_pkg::XFER_IDLE;
			edge_cnt_ff <= 5'h00;
		end else begin
			case (state_ff)
				ssp_pkg::XFER_IDLE: begin
					if (start) begin
						state_ff    <= ssp_pkg::XFER_SHIFT;
						edge_cnt_ff <= 5'h00;
					end else if (s_tick) begin
						state_ff    <= ssp_pkg::XFER_SHIFT;
						edge_cnt_ff <= edge_nxt;
					end
				end
				ssp_pkg::XFER_SHIFT: begin
					if (abort | last) begin
						state_ff    <= ssp_pkg::XFER_IDLE;
						edge_cnt_ff <= 5'h00;
					end else if (tick) begin
						edge_cnt_ff <= edge_nxt;
					end
				end
				default: begin
					state_ff    <= ssp_pkg::XFER_IDLE;
					edge_cnt_ff <= 5'h00;
				end
			endcase
		end
	end

	// Master clock divider and generated serial clock
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			div_cnt_ff <= 5'h00;
			sclk_ff    <= 1'b0;
		end else if (~bus_en_ff | ~busy | ~master) begin
			div_cnt_ff <= reload;
			sclk_ff    <= 1'b0;
		end else if (m_tick) begin
			div_cnt_ff <= reload;
			sclk_ff    <= ~sclk_ff & ~last;
		end else begin
			div_cnt_ff <= div_cnt_ff - 5'h01;
		end
	end

	// writes land in shift buffer only
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			shift_buf_ff <= 8'h00;
		end else if (bus_en_ff & wr_data & ~busy) begin
			shift_buf_ff <= pwdata_i[7:0];
		end else if (tick & sample) begin
			shift_buf_ff <= shifted;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_reg_ff <= 8'h00;
		end else if (last) begin
			data_reg_ff <= sample ? shifted : shift_buf_ff;
		end
	end

	// Serial out: holds a bit between drive edges
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sdo_ff <= 1'b0;
		end else if (bus_en_ff & ~bus_en_d_ff) begin
			sdo_ff <= 1'b0;
		end else if (bus_en_ff & wr_data & ~busy) begin
			sdo_ff <= head_bit(order_ff, pwdata_i[7:0]);
		end else if (tick & ~sample) begin
			sdo_ff <= head_bit(order_ff, shift_buf_ff);
		end
	end

	// Done flag: a completing transfer wins over a clear
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			trf_ff <= 1'b0;
		end else if (last) begin
			trf_ff <= 1'b1;
		end else if (~bus_en_ff) begin
			trf_ff <= 1'b0;
		end else if (wr_ctrl & ~pwdata_i[`SSP_TRF_BIT]) begin
			trf_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			write_collision_flag_ff <= 1'b0;
		end else if (wr_data & busy) begin
			write_collision_flag_ff <= 1'b1;
		end else if (~bus_en_ff) begin
			write_collision_flag_ff <= 1'b0;
		end else if (wr_ctrl & ~pwdata_i[`SSP_WRITE_COLLISION_FLAG_BIT]) begin
			write_collision_flag_ff <= 1'b0;
		end
	end

	// Pin drivers; enables follow the control fields one cycle later
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bus_en_d_ff <= 1'b0;
			sclk_oe_ff  <= 1'b0;
			sdo_oe_ff   <= 1'b0;
			ss_oe_ff    <= 1'b0;
			ss_n_ff     <= 1'b1;
		end else begin
			bus_en_d_ff <= bus_en_ff;
			sclk_oe_ff  <= bus_en_ff & master;
			sdo_oe_ff   <= bus_en_ff;
			ss_oe_ff    <= bus_en_ff & master & sel_en_ff;
			// select low on enable
			// Released after each byte so the peer sees a frame end
			if (~bus_en_ff | last) begin
				ss_n_ff <= 1'b1;
			end else if ((bus_en_ff & ~bus_en_d_ff) | start) begin
				ss_n_ff <= 1'b0;
			end
		end
	end

	assign prdata_o            = prdata_ff;
	assign pready_o            = pready_ff;
	assign pslverr_o           = pslverr_ff;
	assign serial_clk_o        = sclk_ff;
	assign serial_clk_oe_o     = sclk_oe_ff;
	assign serial_out_o        = sdo_ff;
	assign serial_out_oe_o     = sdo_oe_ff;
	assign slave_select_n_o    = ss_n_ff;
	assign slave_select_n_oe_o = ss_oe_ff;
	assign serial_bus_irq_o    = trf_ff;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_master_start;
		bus_en_ff && master && wr_data && !busy;
	endsequence

	sequence s_done;
		last;
	endsequence

	AST_FLOAT_OFF: assert property (!bus_en_ff |=>
		!serial_clk_oe_o && !serial_out_oe_o && !slave_select_n_oe_o)
		else $error("serial pins driven while bus disabled");

	AST_SEL_FLOAT: assert property (!sel_en_ff |=> !slave_select_n_oe_o)
		else $error("select pin driven with select disabled");

	AST_START: assert property (s_master_start |=> busy
		&& shift_buf_ff == $past(pwdata_i[7:0]))
		else $error("master write did not start transfer");

	AST_COLLIDE: assert property (wr_data && busy && !abort && !last |=>
		write_collision_flag_ff && busy)
		else $error("collision flag not set on busy write");

	AST_DONE: assert property (s_done |=> trf_ff && serial_bus_irq_o
		&& !busy)
		else $error("done flag or interrupt missing after transfer");

	AST_LATCH: assert property (s_done |=>
		data_reg_ff == $past(sample ? shifted : shift_buf_ff))
		else $error("received byte not latched");

	AST_READ: assert property (setup && !pwrite_i && hit_data |=>
		pready_o && prdata_o[7:0] == $past(data_reg_ff))
		else $error("data read did not return data register");

	AST_DIS_CLR: assert property (!bus_en_ff && !last |=> !trf_ff
		&& (!write_collision_flag_ff || $past(wr_data && busy)))
		else $error("flags survive bus disable");

	AST_EDGES: assert property (busy |-> edge_cnt_ff < `SSP_EDGES)
		else $error("edge count exceeds one byte");

	AST_DIV: assert property (busy && master && $changed(sclk_ff)
		|-> $past(div_cnt_ff) == 5'h00)
		else $error("serial clock toggled off divider tick");

	AST_ENABLE_LOW: assert property ($rose(bus_en_ff) |=>
		!serial_out_o && !serial_clk_o && !slave_select_n_o)
		else $error("lines not low after enable");

endmodule
`default_nettype wire

// ### include/ssp_consts.svh
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// Register byte addresses on the APB
`define SSP_CTRL_OFS 8'h00
`define SSP_DATA_OFS 8'h04

// Control register reset value and field positions
`define SSP_CTRL_RST 8'h60
`define SSP_CKS_BIT 7
`define SSP_MODE_HI_BIT 6
`define SSP_MODE_LO_BIT 5
`define SSP_EN_BIT 4
`define SSP_ORDER_BIT 3
`define SSP_SEL_EN_BIT 2
`define SSP_WRITE_COLLISION_FLAG_BIT 1
`define SSP_TRF_BIT 0

// Mode select encodings
`define SSP_MODE_DIV1 2'h0
`define SSP_MODE_DIV4 2'h1
`define SSP_MODE_DIV16 2'h2
`define SSP_MODE_SLAVE 2'h3

// Serial clock edges in one byte transfer
`define SSP_EDGES 5'h10

// Half-period reloads (cycles minus one), unit clock = system / 4
`define SSP_HALF_Q_DIV1 5'h01
`define SSP_HALF_Q_DIV4 5'h07
`define SSP_HALF_Q_DIV16 5'h1F

// Half-period reloads, unit clock = system clock
`define SSP_HALF_F_DIV1 5'h00
`define SSP_HALF_F_DIV4 5'h01
`define SSP_HALF_F_DIV16 5'h07

`endif

// ### include/ssp_pkg.sv
package ssp_pkg;

	typedef enum logic {
		XFER_IDLE,
		XFER_SHIFT
	} xfer_state_t;

endpackage

// ### testbench/ssp_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
	input  wire logic sck_i,
	input  wire logic ssn_i,
	input  wire logic sdo_i,
	output logic      sck_o,
	output logic      ssn_o,
	output logic      sdi_o
);
	logic [7:0] tx = 8'h00;
	logic [7:0] rx = 8'h00;
	bit         msb;
	bit         sel_bad;
	int         edges;
	realtime    t_prev;
	realtime    t_rise;

	initial begin
		sck_o = 1'b0;
		ssn_o = 1'b1;
		sdi_o = 1'b0;
	end

	function automatic logic pick(input int k);
		return msb ? tx[7 - k] : tx[k];
	endfunction

	task automatic load(input logic [7:0] b, input bit m);
		tx = b;
		msb = m;
		edges = 0;
		sel_bad = 1'b0;
		sdi_o = pick(0);
	endtask

	always @(posedge sck_i) begin
		rx = msb ? {rx[6:0], sdo_i} : {sdo_i, rx[7:1]};
		if (ssn_i !== 1'b0) sel_bad = 1'b1;
		edges++;
		t_prev = t_rise;
		t_rise = $realtime;
	end

	// Released line flips so a stale bit cannot pass as data
	always @(negedge sck_i) begin
		if (edges < 8) sdi_o = pick(edges);
		else sdi_o = ~sdi_o;
	end

	task automatic drive(input logic [7:0] b, input bit m, input realtime half);
		load(b, m);
		ssn_o = 1'b0;
		#(half);
		repeat (8) begin
			sck_o = 1'b1;
			#(half);
			sck_o = 1'b0;
			#(half);
		end
		ssn_o = 1'b1;
	endtask
endmodule
`default_nettype wire

// ### testbench/tb_sync_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "ssp_consts.svh"
module tb_sync_serial_port;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, clk_o, clk_oe, serial_out, sdo_oe, ssn_o, ssn_oe, irq;
	logic        p_sck, p_ssn, p_sdi, last_err;
	int          failures = 0;
	int          n_compared = 0;
	wire logic   sck_w = clk_oe ? clk_o : p_sck;
	wire logic   ssn_w = ssn_oe ? ssn_o : p_ssn;
	wire logic   sdo_w = sdo_oe ? serial_out : 1'b1;

	always #4 clk = ~clk;

	sync_serial_port i_dut (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .serial_clk_i(sck_w), .serial_clk_o(clk_o),
		.serial_clk_oe_o(clk_oe), .serial_in_i(p_sdi), .serial_out_o(serial_out), .serial_out_oe_o(sdo_oe),
		.slave_select_n_i(ssn_w), .slave_select_n_o(ssn_o), .slave_select_n_oe_o(ssn_oe),
		.serial_bus_irq_o(irq));

	ssp_peer p (.sck_i(sck_w), .ssn_i(ssn_w), .sdo_i(sdo_w), .sck_o(p_sck), .ssn_o(p_ssn), .sdi_o(p_sdi));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		if (failures == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_done(output logic [31:0] r);
		do begin
			apb(1'b0, `SSP_CTRL_OFS, 32'h0, r);
		end while (r[0] !== 1'b1);
	endtask

	task automatic t_reset();
		logic [31:0] r;
		apb(1'b0, `SSP_CTRL_OFS, 32'h0, r);
		chk("ctrl", 32'h60, r);
		apb(1'b0, `SSP_DATA_OFS, 32'h0, r);
		chk("data", 32'h0, r);
		apb(1'b0, 8'h08, 32'h0, r);
		chk("slverr", 32'h1, last_err);
		chk("oe", 32'h0, {clk_oe, sdo_oe, ssn_oe});
	endtask

	task automatic t_enable();
		logic [31:0] r;
		apb(1'b1, `SSP_CTRL_OFS, 32'h3C, r);
		// Pin drivers follow the control write one cycle later
		@(posedge clk);
		@(negedge clk);
		chk("lines", 32'h2A, {clk_oe, clk_o, sdo_oe, serial_out, ssn_oe, ssn_o});
	endtask

	// Kind 0 skips the received byte: input sync is too slow at half periods of 1 or 2 cycles
	// Kind 1 checks the received byte, 2 adds a colliding write
	task automatic t_master(input logic [7:0] c, input int per, input logic [7:0] tx, input logic [7:0] pb,
		input int kind);
		logic [31:0] r;
		apb(1'b1, `SSP_CTRL_OFS, {24'h0, c}, r);
		p.load(pb, c[3]);
		apb(1'b1, `SSP_DATA_OFS, {24'h0, tx}, r);
		if (kind > 1) apb(1'b1, `SSP_DATA_OFS, {24'h0, ~tx}, r);
		wait_done(r);
		if (kind > 1) chk("write_collision_flag", 32'h1, r[1]);
		chk("period", per, int'((p.t_rise - p.t_prev) / 8.0));
		chk("edges", 32'h8, p.edges);
		chk("irq", 32'h1, irq);
		if (!c[2]) chk("ssn oe", 32'h0, ssn_oe);
		chk("sent", tx, p.rx);
		if (c[2]) chk("sel", 32'h0, p.sel_bad);
		if (kind > 0) begin
			apb(1'b0, `SSP_DATA_OFS, 32'h0, r);
			chk("rdata", {24'h0, pb}, r);
		end
		apb(1'b1, `SSP_CTRL_OFS, {24'h0, c & 8'hFC}, r);
		@(negedge clk);
		chk("irq clr", 32'h0, irq);
	endtask

	task automatic t_slave();
		logic [31:0] r;
		apb(1'b1, `SSP_CTRL_OFS, 32'h7F, r);
		apb(1'b1, `SSP_DATA_OFS, 32'hC3, r);
		apb(1'b0, `SSP_DATA_OFS, 32'h0, r);
		chk("rdata old", 32'h5A, r);
		p.drive(8'h96, 1'b1, 43.0);
		wait_done(r);
		chk("slave sent", 32'hC3, p.rx);
		apb(1'b0, `SSP_DATA_OFS, 32'h0, r);
		chk("slave rdata", 32'h96, r);
	endtask

	task automatic t_disable();
		logic [31:0] r;
		apb(1'b1, `SSP_CTRL_OFS, 32'h6F, r);
		apb(1'b0, `SSP_CTRL_OFS, 32'h0, r);
		chk("flags off", 32'h6C, r);
		chk("oe off", 32'h0, {clk_oe, sdo_oe, ssn_oe});
	endtask

	initial begin
		#(20000 * 8);
		failures++;
		finish_test();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_enable();
		t_master(8'h3F, 16, 8'hA5, 8'h3C, 2);
		t_master(8'h53, 64, 8'h81, 8'hE7, 1);
		t_master(8'h17, 4, 8'h11, 8'h22, 0);
		t_master(8'hBF, 4, 8'h33, 8'h44, 0);
		t_master(8'h97, 2, 8'h55, 8'h66, 0);
		// Last master byte leaves the data register the slave test reads first
		t_master(8'hDF, 16, 8'h4E, 8'h5A, 1);
		t_slave();
		t_disable();
		finish_test();
	end
endmodule
`default_nettype wire
